// [pxs_crossover_ctrl.sv]
// Purpose: crossover source select, heartbeat and pll controls with a polarity indication
// Assumes: straps are latched at the release of reset; inputs synchronous to core_clk
// Notes: zero-wait AHB-Lite slave, responses always OKAY
`timescale 1ns/10ps
// Notes on behaviour
// - select set: straps ignored, software bits decide
// - select clear (reset): latched straps decide
// - software 00 straight, 01 cross, 10 auto
// - auto strap wins; else manual strap decides
// - latched auto strap readable in config register
// - heartbeat disable resets 0; 1 suppresses test
// - pll lock bit forces reference, blocks 10M
// - read-only polarity bit, 1 reversed, resets 0
// - control bits default on soft phy reset
// - register at index 27, 16 bits wide
module pxs_crossover_ctrl (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// straps and phy status
	input wire pxs_pkg::pxs_strap_t strap_in,
	input wire logic polarity_reversed_in,
	// controls to the phy
	output pxs_pkg::pxs_mode_t crossover_mode,
	output logic heartbeat_test_disable,
	output logic rx_pll_reference_lock,
	output logic rx_10m_block,
	output logic phy_soft_reset
);
	import pxs_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	pxs_ctrl_t ctrl_q, ctrl_d;
	pxs_strap_t strap_q, strap_d;
	logic strap_taken_q, strap_taken_d;
	logic soft_en_q, soft_en_d;
	logic pol_q, pol_d;
	logic wr_pend_q, wr_pend_d;
	logic [PXS_ADDR_W-1:0] wr_addr_q, wr_addr_d;
	logic [31:0] rdata_q, rdata_d;
	logic rst_pulse_q, rst_pulse_d;
	pxs_mode_t mode_q, mode_d;
	logic addr_ok;
	logic [15:0] word_now;
	logic ready_q;
	logic resp_q;

	function automatic pxs_mode_t pxs_decode(input logic auto_b, input logic man_b, input logic strap_src);
		if (auto_b && !(strap_src == 1'b0 && man_b)) begin
			pxs_decode = PXS_MODE_AUTO;
		end else if (auto_b) begin
			// reserved software code 11: hold straight-through as the safe choice
			pxs_decode = strap_src ? PXS_MODE_AUTO : PXS_MODE_STRAIGHT;
		end else if (man_b) begin
			pxs_decode = PXS_MODE_CROSS;
		end else begin
			pxs_decode = PXS_MODE_STRAIGHT;
		end
	endfunction : pxs_decode

	function automatic logic [15:0] pxs_pack(input pxs_ctrl_t c, input logic p);
		logic [15:0] w;
		w = 16'h0000;
		w[PXS_BIT_SRC_SEL] = c.src_sel;
		w[PXS_BIT_AUTO_EN] = c.auto_en;
		w[PXS_BIT_MAN_STATE] = c.man_state;
		w[PXS_BIT_HB_DIS] = c.hb_dis;
		w[PXS_BIT_PLL_LOCK] = c.pll_lock;
		w[PXS_BIT_POL_REV] = p;
		pxs_pack = w;
	endfunction : pxs_pack

	// ----------------------------------------
	// bus and register logic
	// ----------------------------------------
	assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'b010);
	assign word_now = pxs_pack(ctrl_q, pol_q);

	always_comb begin
		ctrl_d = ctrl_q;
		strap_d = strap_q;
		strap_taken_d = 1'b1;
		soft_en_d = soft_en_q;
		pol_d = polarity_reversed_in;
		wr_pend_d = 1'b0;
		wr_addr_d = wr_addr_q;
		rdata_d = rdata_q;
		rst_pulse_d = 1'b0;
		if (!strap_taken_q) begin
			strap_d = strap_in;
		end
		if (wr_pend_q) begin
			case (wr_addr_q)
				PXS_ADDR_SPECIAL: begin
					ctrl_d.src_sel = hwdata[PXS_BIT_SRC_SEL];
					ctrl_d.auto_en = hwdata[PXS_BIT_AUTO_EN];
					ctrl_d.man_state = hwdata[PXS_BIT_MAN_STATE];
					ctrl_d.hb_dis = hwdata[PXS_BIT_HB_DIS];
					ctrl_d.pll_lock = hwdata[PXS_BIT_PLL_LOCK];
				end
				PXS_ADDR_RESETCTL: begin
					soft_en_d = hwdata[PXS_BIT_RST_SOFT_EN];
					if (hwdata[PXS_BIT_RST_PHY] && hwdata[PXS_BIT_RST_SOFT_EN]) begin
						ctrl_d = pxs_ctrl_t'(PXS_CTRL_RESET[4:0]);
						rst_pulse_d = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		if (addr_ok) begin
			if (hwrite) begin
				wr_pend_d = 1'b1;
				wr_addr_d = haddr[PXS_ADDR_W-1:0];
			end else begin
				case (haddr[PXS_ADDR_W-1:0])
					// forwarded so a read right behind a write returns the new word
					PXS_ADDR_SPECIAL: rdata_d = {16'h0000, pxs_pack(ctrl_d, pol_q)};
					PXS_ADDR_HWCFG: begin
						rdata_d = 32'h0000_0000;
						rdata_d[PXS_BIT_HW_AUTO_STRAP] = strap_q.auto_strap;
						rdata_d[PXS_BIT_HW_MAN_STRAP] = strap_q.man_strap;
					end
					PXS_ADDR_RESETCTL: begin
						rdata_d = 32'h0000_0000;
						rdata_d[PXS_BIT_RST_SOFT_EN] = soft_en_d;
					end
					default: rdata_d = 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// crossover source and decode
	// ----------------------------------------
	always_comb begin
		if (ctrl_q.src_sel) begin
			mode_d = pxs_decode(ctrl_q.auto_en, ctrl_q.man_state, 1'b0);
		end else begin
			mode_d = pxs_decode(strap_q.auto_strap, strap_q.man_strap, 1'b1);
		end
	end

	// ----------------------------------------
	// registers, one block per group of state
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= pxs_ctrl_t'(PXS_CTRL_RESET[4:0]);
		end else if (clk_en) begin
			ctrl_q <= ctrl_d;
		end
	end

	// straps are taken once; a soft phy reset does not sample them again
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			strap_q <= '0;
			strap_taken_q <= 1'b0;
		end else if (clk_en) begin
			strap_q <= strap_d;
			strap_taken_q <= strap_taken_d;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			soft_en_q <= 1'b0;
			rst_pulse_q <= 1'b0;
		end else if (clk_en) begin
			soft_en_q <= soft_en_d;
			rst_pulse_q <= rst_pulse_d;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pol_q <= 1'b0;
		end else if (clk_en) begin
			pol_q <= pol_d;
		end
	end

	// ready and response are flops so every output leaves a register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			rdata_q <= 32'h0000_0000;
			ready_q <= 1'b1;
			resp_q <= 1'b0;
		end else if (clk_en) begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			rdata_q <= rdata_d;
			ready_q <= 1'b1;
			resp_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mode_q <= PXS_MODE_STRAIGHT;
		end else if (clk_en) begin
			mode_q <= mode_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// read data is registered at the address phase, so it is stable through the data phase
	assign hrdata = rdata_q;
	assign hreadyout = ready_q;
	assign hresp = resp_q;
	assign crossover_mode = mode_q;
	assign heartbeat_test_disable = ctrl_q.hb_dis;
	assign rx_pll_reference_lock = ctrl_q.pll_lock;
	assign rx_10m_block = ctrl_q.pll_lock;
	assign phy_soft_reset = rst_pulse_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sw_source_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && ctrl_q.src_sel && !ctrl_q.auto_en && ctrl_q.man_state) |=> (!clk_en || mode_q == PXS_MODE_CROSS))
		else $error("software crossover select not honoured");
	sw_auto_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && ctrl_q.src_sel && ctrl_q.auto_en && !ctrl_q.man_state) |=> (!clk_en || mode_q == PXS_MODE_AUTO))
		else $error("software auto code not decoded");
	strap_auto_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && !ctrl_q.src_sel && strap_q.auto_strap) |=> (!clk_en || mode_q == PXS_MODE_AUTO))
		else $error("auto strap did not win");
	strap_manual_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && !reset && !ctrl_q.src_sel && !strap_q.auto_strap) |=>
		(!clk_en || mode_q == ($past(strap_q.man_strap) ? PXS_MODE_CROSS : PXS_MODE_STRAIGHT)))
		else $error("manual strap not followed");
	pol_track_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && !reset) |=> (!clk_en || pol_q == $past(polarity_reversed_in)))
		else $error("polarity indication stale");
	reserved_zero_a: assert property (@(posedge core_clk) disable iff (reset)
		(word_now & 16'h13ef) == 16'h0000)
		else $error("reserved bits not zero");
	soft_reset_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && rst_pulse_d) |=> (ctrl_q == '0 && phy_soft_reset))
		else $error("soft reset did not clear controls");
	pll_block_a: assert property (@(posedge core_clk) disable iff (reset)
		rx_pll_reference_lock == rx_10m_block && rx_pll_reference_lock == word_now[PXS_BIT_PLL_LOCK])
		else $error("pll lock and 10M block disagree");
	hb_write_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && wr_pend_q && wr_addr_q == PXS_ADDR_SPECIAL) |=> (heartbeat_test_disable == $past(hwdata[PXS_BIT_HB_DIS])))
		else $error("heartbeat disable write lost");
	sw_straight_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && ctrl_q.src_sel && !ctrl_q.auto_en && !ctrl_q.man_state) |=> (!clk_en || mode_q == PXS_MODE_STRAIGHT))
		else $error("software straight code not decoded");
	sw_reserved_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && ctrl_q.src_sel && ctrl_q.auto_en && ctrl_q.man_state) |=> (!clk_en || mode_q == PXS_MODE_STRAIGHT))
		else $error("reserved software code not held safe");
	src_write_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && !reset && wr_pend_q && wr_addr_q == PXS_ADDR_SPECIAL) |=>
		(ctrl_q.src_sel == $past(hwdata[PXS_BIT_SRC_SEL])))
		else $error("source select write lost");
	pll_write_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && !reset && wr_pend_q && wr_addr_q == PXS_ADDR_SPECIAL) |=>
		(rx_pll_reference_lock == $past(hwdata[PXS_BIT_PLL_LOCK])))
		else $error("pll lock write lost");
	mode_onehot_a: assert property (@(posedge core_clk) disable iff (reset)
		$onehot(crossover_mode))
		else $error("crossover mode not one-hot");

	// ----------------------------------------
	// strap and read checks
	// ----------------------------------------
	strap_latch_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && !reset && !strap_taken_q) |=> (strap_q == $past(strap_in)))
		else $error("straps not latched");
	strap_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && !reset && strap_taken_q) |=> (strap_q == $past(strap_q)))
		else $error("latched straps moved");
	hwcfg_read_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && !reset && addr_ok && !hwrite && haddr[PXS_ADDR_W-1:0] == PXS_ADDR_HWCFG) |=>
		(hrdata[PXS_BIT_HW_AUTO_STRAP] == $past(strap_q.auto_strap)))
		else $error("auto strap state not readable");
	special_read_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && !reset && addr_ok && !hwrite && haddr[PXS_ADDR_W-1:0] == PXS_ADDR_SPECIAL) |=>
		(hrdata[31:16] == 16'h0000))
		else $error("upper half of register not zero");
	pol_read_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && !reset && addr_ok && !hwrite && haddr[PXS_ADDR_W-1:0] == PXS_ADDR_SPECIAL) |=>
		(hrdata[PXS_BIT_POL_REV] == $past(pol_q)))
		else $error("polarity bit not read back");
	unmapped_read_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && !reset && addr_ok && !hwrite && haddr[PXS_ADDR_W-1:0] != PXS_ADDR_SPECIAL &&
		haddr[PXS_ADDR_W-1:0] != PXS_ADDR_HWCFG && haddr[PXS_ADDR_W-1:0] != PXS_ADDR_RESETCTL) |=>
		(hrdata == 32'h0000_0000))
		else $error("unmapped read not zero");
	size_refuse_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && !reset && hsel && hready && htrans[1] && hsize != 3'b010) |=> !wr_pend_q)
		else $error("non-word transfer taken");
	ready_high_a: assert property (@(posedge core_clk) disable iff (reset)
		hreadyout && !hresp)
		else $error("slave not ready or not okay");

	// ----------------------------------------
	// soft reset and clock enable checks
	// ----------------------------------------
	soft_enable_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && !reset && wr_pend_q && wr_addr_q == PXS_ADDR_RESETCTL) |=>
		(soft_en_q == $past(hwdata[PXS_BIT_RST_SOFT_EN])))
		else $error("soft reset enable write lost");
	soft_gate_a: assert property (@(posedge core_clk) disable iff (reset)
		(clk_en && !reset && wr_pend_q && wr_addr_q == PXS_ADDR_RESETCTL && !hwdata[PXS_BIT_RST_SOFT_EN]) |=>
		(!phy_soft_reset && ctrl_q == $past(ctrl_q)))
		else $error("soft reset without its enable");
	freeze_ctrl_a: assert property (@(posedge core_clk) disable iff (reset)
		(!clk_en && !reset) |=> (ctrl_q == $past(ctrl_q) && mode_q == $past(mode_q)))
		else $error("controls moved while frozen");
	freeze_bus_a: assert property (@(posedge core_clk) disable iff (reset)
		(!clk_en && !reset) |=> (rdata_q == $past(rdata_q) && wr_pend_q == $past(wr_pend_q)))
		else $error("bus state moved while frozen");
	freeze_status_a: assert property (@(posedge core_clk) disable iff (reset)
		(!clk_en && !reset) |=> (pol_q == $past(pol_q) && strap_q == $past(strap_q)))
		else $error("status moved while frozen");
endmodule : pxs_crossover_ctrl

// [pxs_crossover_ctrl_tb.sv]
// Purpose: self-checking bench for the crossover special control register
// Assumes: zero-wait slave; mode settles within three edges of a write
// Notes: read results are queued at the address phase and compared by a monitor
`timescale 1ns/10ps
module pxs_crossover_ctrl_tb;
	import pxs_pkg::*;
	logic core_clk, reset, hwrite, pol, hready, hresp, hb, pll, blk, srst, rd_ph, ce;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, r;
	pxs_strap_t straps;
	pxs_mode_t mode;
	logic [31:0] expq[$];
	int failures, n_checks, pulses;
	pxs_crossover_ctrl dut (.core_clk(core_clk), .reset(reset), .clk_en(ce), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .strap_in(straps), .polarity_reversed_in(pol),
		.crossover_mode(mode), .heartbeat_test_disable(hb), .rx_pll_reference_lock(pll),
		.rx_10m_block(blk), .phy_soft_reset(srst));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic pxs_mode_t em(input logic [2:0] sw, input logic [1:0] st);
		if (sw[2])
			return sw[1] ? (sw[0] ? PXS_MODE_STRAIGHT : PXS_MODE_AUTO) : (sw[0] ? PXS_MODE_CROSS : PXS_MODE_STRAIGHT);
		return st[1] ? PXS_MODE_AUTO : (st[0] ? PXS_MODE_CROSS : PXS_MODE_STRAIGHT);
	endfunction : em
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	// one word transfer; for a read d is the expected data
	task automatic ahb(input logic [9:0] a, input logic w, input logic [31:0] d);
		haddr <= {22'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		hsize <= 3'b010;
		if (!w)
			expq.push_back(d);
		do @(posedge core_clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= w ? d : 32'h0;
		do @(posedge core_clk); while (hready !== 1'b1);
	endtask : ahb
	// waits past the write latency, then checks the levels
	task automatic outs(input pxs_mode_t m, input logic [2:0] lv);
		repeat (3) @(posedge core_clk);
		#1;
		chk({29'h0, mode}, {29'h0, m});
		chk({29'h0, hb, pll, blk}, {29'h0, lv});
		@(posedge core_clk);
	endtask : outs
	task automatic rst(input logic [1:0] s);
		reset <= 1'b1;
		straps <= s;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : rst
	// ----------------------------------------
	// clock, monitor, watchdog
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (rd_ph) begin
			chk(hrdata, expq.pop_front());
			chk({31'h0, hresp}, 32'h0);
		end
		if (srst)
			pulses++;
		rd_ph <= !reset && ce && htrans[1] && !hwrite && hready;
	end
	initial begin
		#400000;
		failures++;
		summarize();
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		reset = 1'b1;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		haddr = 32'h0;
		hwdata = 32'h0;
		pol = 1'b0;
		straps = 2'b10;
		rd_ph = 1'b0;
		ce = 1'b1;
		pulses = 0;
		failures = 0;
		n_checks = 0;
		r = 32'hd4e85c9f;
		for (int s = 0; s < 4; s++) begin
			rst(s[1:0]);
			outs(em(3'b000, s[1:0]), 3'b000);
			ahb(PXS_ADDR_HWCFG, 1'b0, {30'h0, s[0], s[1]});
			ahb(PXS_ADDR_SPECIAL, 1'b0, 32'h0);
		end
		// straps say auto, so every software code must win over them
		for (int c = 0; c < 4; c++) begin
			ahb(PXS_ADDR_SPECIAL, 1'b1, (c == 3) ? 32'hffff : {16'h0, 1'b1, c[1:0], 13'h0});
			outs(em({1'b1, c[1:0]}, 2'b11), (c == 3) ? 3'b111 : 3'b000);
		end
		ahb(PXS_ADDR_SPECIAL, 1'b0, 32'hec00);
		pol <= 1'b1;
		repeat (2) @(posedge core_clk);
		ahb(PXS_ADDR_SPECIAL, 1'b0, 32'hec10);
		pol <= 1'b0;
		ahb(10'h3fc, 1'b1, 32'hffff);
		ahb(10'h3fc, 1'b0, 32'h0);
		ahb(PXS_ADDR_SPECIAL, 1'b0, 32'hec00);
		ahb(PXS_ADDR_RESETCTL, 1'b1, 32'h1);
		ahb(PXS_ADDR_SPECIAL, 1'b0, 32'hec00);
		ahb(PXS_ADDR_RESETCTL, 1'b1, 32'h3);
		outs(PXS_MODE_AUTO, 3'b000);
		ahb(PXS_ADDR_SPECIAL, 1'b0, 32'h0);
		ahb(PXS_ADDR_RESETCTL, 1'b0, 32'h2);
		chk(pulses, 32'h1);
		repeat (8) begin
			r = lfsr(r);
			ahb(PXS_ADDR_SPECIAL, 1'b1, {16'h0, r[15:0]});
			ahb(PXS_ADDR_SPECIAL, 1'b0, {16'h0, r[15:0] & PXS_CTRL_WMASK});
			outs(em(r[15:13], 2'b11), {r[11], r[10], r[10]});
		end
		// a write while the enable is low must leave the register untouched
		ce <= 1'b0;
		ahb(PXS_ADDR_SPECIAL, 1'b1, 32'h0);
		ce <= 1'b1;
		ahb(PXS_ADDR_SPECIAL, 1'b0, {16'h0, r[15:0] & PXS_CTRL_WMASK});
		repeat (2) @(posedge core_clk);
		summarize();
	end
endmodule : pxs_crossover_ctrl_tb

// [pxs_pkg.sv]
// Purpose: constants and types for the per-port crossover special control register
// Assumes: one 16-bit register per port, reached over AHB-Lite as one word
// Notes: offsets are byte addresses; only the special register offset is derived from its register index
package pxs_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] PXS_IDX_SPECIAL = 8'h1b;
	localparam logic [9:0] PXS_ADDR_SPECIAL = {PXS_IDX_SPECIAL, 2'b00};
	localparam logic [9:0] PXS_ADDR_HWCFG = 10'h080;
	localparam logic [9:0] PXS_ADDR_RESETCTL = 10'h084;
	localparam int PXS_ADDR_W = 10;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int PXS_BIT_SRC_SEL = 15;
	localparam int PXS_BIT_AUTO_EN = 14;
	localparam int PXS_BIT_MAN_STATE = 13;
	localparam int PXS_BIT_HB_DIS = 11;
	localparam int PXS_BIT_PLL_LOCK = 10;
	localparam int PXS_BIT_POL_REV = 4;
	localparam int PXS_BIT_HW_AUTO_STRAP = 0;
	localparam int PXS_BIT_HW_MAN_STRAP = 1;
	localparam int PXS_BIT_RST_PHY = 0;
	localparam int PXS_BIT_RST_SOFT_EN = 1;
	localparam logic [15:0] PXS_CTRL_WMASK = 16'hec00;
	localparam logic [15:0] PXS_CTRL_RESET = 16'h0000;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		PXS_MODE_STRAIGHT = 3'b001,
		PXS_MODE_CROSS = 3'b010,
		PXS_MODE_AUTO = 3'b100
	} pxs_mode_t;
	typedef struct packed {
		logic src_sel;
		logic auto_en;
		logic man_state;
		logic hb_dis;
		logic pll_lock;
	} pxs_ctrl_t;
	typedef struct packed {
		logic auto_strap;
		logic man_strap;
	} pxs_strap_t;
endpackage : pxs_pkg
